// File: cfp_fmt.sv
`timescale 1ns/1ps
`default_nettype none

module cfp_fmt (
  // frequency in hertz as bcd digits
  input wire cfp_pkg::cfp_bcd_t freq,
  // power reading and mode
  input wire logic power_meter_mode,
  input wire logic pwr_neg,
  input wire logic [1:0][3:0] pwr_mag,
  // formatted display
  output cfp_pkg::cfp_disp_t disp
);
  import cfp_pkg::*;

  function automatic logic nz(input logic [3:0] d);
    nz = (d != 4'h0);
  endfunction

  wire logic ge_ghz = nz(freq[10]) | nz(freq[9]);
  wire logic ge_mhz = ge_ghz | nz(freq[8]) | nz(freq[7]) | nz(freq[6]);
  wire logic ge_khz = ge_mhz | nz(freq[5]) | nz(freq[4]) | nz(freq[3]);
  wire logic [3:0] sign_code = pwr_neg ? DIG_MINUS : DIG_BLANK;

  wire logic [3:0] unit_norm = ge_ghz ? 4'h8 : ge_mhz ? 4'h4 : ge_khz ? 4'h2 : 4'h1;
  wire logic [3:0] unit_pwr = 4'h4;

  genvar i;
  generate
    for (i = 0; i < DIGITS; i++) begin : g_dig
      if (i >= PWR_FREQ_LSD) begin : g_freq
        assign disp.digits[i] = freq[i];
      end else if (i == PWR_SIGN_POS) begin : g_sign
        assign disp.digits[i] = power_meter_mode ? sign_code : freq[i];
      end else if (i < PWR_SIGN_POS) begin : g_pwr
        assign disp.digits[i] = power_meter_mode ? pwr_mag[i] : freq[i];
      end else begin : g_gap
        assign disp.digits[i] = power_meter_mode ? DIG_BLANK : freq[i];
      end
      if (i == DP_GHZ) begin : g_dpg
        assign disp.dp[i] = !power_meter_mode && unit_norm[UNIT_GHZ];
      end else if (i == DP_MHZ) begin : g_dpm
        assign disp.dp[i] = power_meter_mode || unit_norm[UNIT_MHZ];
      end else if (i == DP_KHZ) begin : g_dpk
        assign disp.dp[i] = !power_meter_mode && unit_norm[UNIT_KHZ];
      end else begin : g_dpn
        assign disp.dp[i] = 1'b0;
      end
    end
  endgenerate

  assign disp.unit = power_meter_mode ? unit_pwr : unit_norm;

endmodule // cfp_fmt

`default_nettype wire

// File: cfp_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfp_front_model (
  // driven display and lamps
  input wire cfp_pkg::cfp_disp_t disp,
  input wire cfp_pkg::cfp_lamps_t lamps,
  // what a viewer sees lit
  output logic [1:0] bands_lit,
  output logic [2:0] units_lit
);
  import cfp_pkg::*;
  assign bands_lit = 2'(lamps.band1_hiz) + 2'(lamps.band1_50) + 2'(lamps.band2);
  assign units_lit = 3'($countones(disp.unit));
endmodule // cfp_front_model
`default_nettype wire

// File: cfp_panel.sv
// Contract
// - show measured frequency on eleven digits with placeable decimal point
// - light the unit annunciator matching the displayed frequency scale
// - power mode: six top digits frequency at 100 kHz, three low digits dBm
// - positive power without sign, negative power with minus symbol
// - standby lamp in standby; battery variant lights it while switched on
// - remote lamp lit while under remote bus control
// - gate lamp lit while the count gate is open
// - hold time on two lamps: short, long, both infinite, none minimum
// - delta lamp whenever delta active, from key or remote command
// - overload lamp while high band input level exceeds the limit
// - dBm lamp lit while power measurement mode is active
// - three band lamps, the selected input's lamp lit
// - power mode allowed only in the high band
// - each display-time key press advances hold selection one step, cyclic
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module cfp_panel (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output var logic S_AXI_AWREADY,
  input wire logic [cfp_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output var logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output var logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output var logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output var logic S_AXI_ARREADY,
  input wire logic [cfp_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output var logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output var logic [31:0] S_AXI_RDATA,
  output var logic [1:0] S_AXI_RRESP,
  // measurement core
  input wire cfp_pkg::cfp_bcd_t FREQ,
  input wire cfp_pkg::cfp_meas_t MEAS,
  // front panel keys, one-cycle pulses
  input wire cfp_pkg::cfp_keys_t KEYS,
  // display and lamps
  output var cfp_pkg::cfp_disp_t DISP,
  output var cfp_pkg::cfp_lamps_t LAMPS,
  // timebase select and interrupt
  output var logic TIMEBASE_EXT,
  output var logic IRQ
);
  import cfp_pkg::*;

  // ---------------- panel state ----------------
  cfp_hold_t hold_reg, hold_next;
  cfp_band_t band_reg, band_next;
  logic pwr_pref_reg;
  logic delta_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ext_act_reg;
  logic ovld_reg;
  logic pwr_eff_reg;

  // ---------------- bus slave state ----------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // ---------------- hold and band stepping ----------------
  // cyclic hold step
  always_comb begin
    case (hold_reg)
      HOLD_MIN: hold_next = HOLD_SHORT;
      HOLD_SHORT: hold_next = HOLD_LONG;
      HOLD_LONG: hold_next = HOLD_INF;
      HOLD_INF: hold_next = HOLD_MIN;
      default: hold_next = HOLD_MIN;
    endcase
  end

  always_comb begin
    case (band_reg)
      BAND1_HIZ: band_next = BAND1_50;
      BAND1_50: band_next = BAND2;
      BAND2: band_next = BAND1_HIZ;
      default: band_next = BAND1_HIZ;
    endcase
  end

  // power mode only in high band
  wire logic in_band2 = (band_reg == BAND2);
  wire logic pwr_eff = pwr_pref_reg & in_band2;

  wire logic ext_act = MEAS.ext_present & MEAS.ext_level_ok;
  wire logic ext_lost = ext_act_reg & ~ext_act;
  wire logic ovld_rise = MEAS.overload_det & ~ovld_reg;

  // ---------------- register access decode ----------------
  wire logic wr_fire = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
  wire logic wr_ctrl = wr_fire && (aw_addr_reg == CTRL_OFS) && w_strb_reg[0];
  wire logic wr_stat = wr_fire && (aw_addr_reg == IRQ_STAT_OFS) && w_strb_reg[0];
  wire logic wr_mask = wr_fire && (aw_addr_reg == IRQ_MASK_OFS) && w_strb_reg[0];
  wire logic wr_hit;
  wire logic rd_hit;
  wire logic [31:0] rd_data;
  wire logic [31:0] status_word;
  wire logic ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire logic delta_set = wr_ctrl & w_data_reg[CTRL_DSET_BIT];
  wire logic delta_clr = wr_ctrl & w_data_reg[CTRL_DCLR_BIT];

  assign wr_hit = (aw_addr_reg == CTRL_OFS) || (aw_addr_reg == IRQ_STAT_OFS) ||
                  (aw_addr_reg == IRQ_MASK_OFS) || (aw_addr_reg == STATUS_OFS);
  assign rd_hit = (S_AXI_ARADDR == CTRL_OFS) || (S_AXI_ARADDR == STATUS_OFS) ||
                  (S_AXI_ARADDR == IRQ_STAT_OFS) || (S_AXI_ARADDR == IRQ_MASK_OFS);

  assign status_word = {22'h0, ctrl_reg[CTRL_STANDBY_BIT], MEAS.gate_open, ovld_reg,
                        ext_act_reg, delta_reg, hold_reg, pwr_eff_reg, band_reg};

  wire logic [31:0] rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl_reg};
  wire logic [31:0] rd_stat = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
  wire logic [31:0] rd_mask = {{(32-IRQ_W){1'b0}}, irq_mask_reg};

  assign rd_data = (S_AXI_ARADDR == CTRL_OFS) ? rd_ctrl :
                   (S_AXI_ARADDR == STATUS_OFS) ? status_word :
                   (S_AXI_ARADDR == IRQ_STAT_OFS) ? rd_stat :
                   (S_AXI_ARADDR == IRQ_MASK_OFS) ? rd_mask : 32'h0000_0000;

  // ---------------- interrupt events ----------------
  wire logic [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_HOLD] = KEYS.hold;
  assign irq_events[IRQ_BAND] = KEYS.band;
  assign irq_events[IRQ_EXTLOST] = ext_lost;
  assign irq_events[IRQ_OVLD] = ovld_rise;
  assign irq_events[IRQ_PWR] = KEYS.power_meter_mode & in_band2;

  // set wins over a same-cycle write-one clear
  wire logic [IRQ_W-1:0] irq_clr = wr_stat ? w_data_reg[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire logic [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_events;

  // ---------------- formatter ----------------
  cfp_disp_t disp_fmt;

  cfp_fmt u_fmt (
    .freq(FREQ),
    .power_meter_mode(pwr_eff),
    .pwr_neg(MEAS.pwr_neg),
    .pwr_mag(MEAS.pwr_mag),
    .disp(disp_fmt)
  );

  // ---------------- lamp decode ----------------
  cfp_lamps_t lamps_next;

  assign lamps_next.standby = ctrl_reg[CTRL_BATT_BIT] ? ctrl_reg[CTRL_PWRON_BIT] :
                              ctrl_reg[CTRL_STANDBY_BIT];
  assign lamps_next.remote = MEAS.remote;
  assign lamps_next.external_timebase_lamp = ext_act;
  assign lamps_next.gate = MEAS.gate_open;
  assign lamps_next.short_hold_lamp = (hold_reg == HOLD_SHORT) || (hold_reg == HOLD_INF);
  assign lamps_next.long_hold_lamp = (hold_reg == HOLD_LONG) || (hold_reg == HOLD_INF);
  assign lamps_next.delta = delta_reg;
  assign lamps_next.overload = MEAS.overload_det;
  assign lamps_next.dbm = pwr_eff;
  assign lamps_next.band1_hiz = (band_reg == BAND1_HIZ);
  assign lamps_next.band1_50 = (band_reg == BAND1_50);
  assign lamps_next.band2 = in_band2;

  // ---------------- panel state registers ----------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hold_reg <= HOLD_MIN;
      band_reg <= BAND1_HIZ;
    end else begin
      if (KEYS.hold) begin
        hold_reg <= hold_next;
      end
      if (KEYS.band) begin
        band_reg <= band_next;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pwr_pref_reg <= 1'b0;
      delta_reg <= 1'b0;
    end else begin
      if (KEYS.power_meter_mode && in_band2) begin
        pwr_pref_reg <= ~pwr_pref_reg;
      end
      // key toggles, command sets or clears
      if (delta_set) begin
        delta_reg <= 1'b1;
      end else if (delta_clr) begin
        delta_reg <= 1'b0;
      end else if (KEYS.delta) begin
        delta_reg <= ~delta_reg;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[CTRL_W-1:0];
    end else if (KEYS.standby) begin
      ctrl_reg[CTRL_STANDBY_BIT] <= ~ctrl_reg[CTRL_STANDBY_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      IRQ <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_mask) begin
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
      end
      IRQ <= |(irq_stat_next & (wr_mask ? w_data_reg[IRQ_W-1:0] : irq_mask_reg));
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ext_act_reg <= 1'b0;
      ovld_reg <= 1'b0;
      pwr_eff_reg <= 1'b0;
      TIMEBASE_EXT <= 1'b0;
    end else begin
      ext_act_reg <= ext_act;
      ovld_reg <= MEAS.overload_det;
      pwr_eff_reg <= pwr_eff;
      TIMEBASE_EXT <= ext_act;
    end
  end

  // ---------------- output registers ----------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DISP <= '0;
      LAMPS <= '0;
    end else begin
      DISP <= disp_fmt;
      LAMPS <= lamps_next;
    end
  end

  // ---------------- axi4-lite write channel ----------------
  // readies are registered from the next holding state, so they match the
  // combinational form cycle for cycle while coming straight from flops
  wire logic aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire logic w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire logic bvalid_nx = wr_fire | (S_AXI_BVALID & ~S_AXI_BREADY);
  wire logic aw_have_nx = ~wr_fire & (aw_have_reg | aw_take);
  wire logic w_have_nx = ~wr_fire & (w_have_reg | w_take);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_have_nx & ~bvalid_nx;
      S_AXI_WREADY <= ~w_have_nx & ~bvalid_nx;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[AXI_AW-1:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ---------------- axi4-lite read channel ----------------
  wire logic rvalid_nx = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~rvalid_nx;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule // cfp_panel

`default_nettype wire

// File: cfp_panel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cfp_panel_asserts (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // core and keys
  input wire cfp_pkg::cfp_bcd_t FREQ,
  input wire cfp_pkg::cfp_meas_t MEAS,
  input wire cfp_pkg::cfp_keys_t KEYS,
  // panel
  input wire cfp_pkg::cfp_disp_t DISP,
  input wire cfp_pkg::cfp_lamps_t LAMPS
);
  import cfp_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  AST_DIGITS: assert property (
    !$past(RST) && !LAMPS.dbm |-> DISP.digits == $past(FREQ)) else $error("digits wrong");
  AST_GHZ: assert property (
    !$past(RST) && !LAMPS.dbm |->
    DISP.unit[UNIT_GHZ] == ($past(FREQ[10]) != 4'h0 || $past(FREQ[9]) != 4'h0))
    else $error("GHz lamp wrong");
  AST_SPLIT: assert property (
    LAMPS.dbm |-> DISP.digits[10:5] == $past(FREQ[10:5]) && DISP.digits[4] == DIG_BLANK
    && DISP.digits[3] == DIG_BLANK && DISP.unit == 4'h4) else $error("split wrong");
  AST_SIGN: assert property (
    LAMPS.dbm |-> DISP.digits[PWR_SIGN_POS] == ($past(MEAS.pwr_neg) ? DIG_MINUS : DIG_BLANK))
    else $error("sign wrong");
  AST_REMOTE: assert property (
    !$past(RST) |-> LAMPS.remote == $past(MEAS.remote)) else $error("remote lamp wrong");
  AST_EXT: assert property (
    !$past(RST) |-> LAMPS.external_timebase_lamp == $past(MEAS.ext_present && MEAS.ext_level_ok))
    else $error("ext lamp wrong");
  AST_GATE: assert property (
    !$past(RST) |-> LAMPS.gate == $past(MEAS.gate_open)) else $error("gate lamp wrong");
  AST_OVLD: assert property (
    !$past(RST) |-> LAMPS.overload == $past(MEAS.overload_det)) else $error("overload wrong");
  AST_DBM: assert property (
    LAMPS.dbm |-> LAMPS.band2) else $error("dbm outside high band");
  AST_ONE: assert property (
    !$past(RST) |-> $onehot({LAMPS.band1_hiz, LAMPS.band1_50, LAMPS.band2}) && $onehot0(DISP.unit))
    else $error("lamp count wrong");
  AST_HOLD: assert property (
    $past(KEYS.hold, 2) && !$past(RST, 2) && !$past(RST) |->
    {LAMPS.short_hold_lamp, LAMPS.long_hold_lamp} == {~$past(LAMPS.short_hold_lamp),
    $past(LAMPS.short_hold_lamp ^ LAMPS.long_hold_lamp)})
    else $error("hold step wrong");
endmodule // cfp_panel_asserts
bind cfp_panel cfp_panel_asserts chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .FREQ(FREQ),
  .MEAS(MEAS), .KEYS(KEYS), .DISP(DISP), .LAMPS(LAMPS));
`default_nettype wire

// File: cfp_panel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfp_panel_tb;
  import cfp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic awr, wrd, bv, arr, rv, irq, tbx;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] bresp, rresp, r, bl;
  logic [2:0] ul;
  cfp_bcd_t freq = '0;
  cfp_meas_t meas = '0;
  cfp_keys_t keys = '0;
  cfp_disp_t disp;
  cfp_lamps_t lamps;
  int num_errors = 0, n_compared = 0, cyc = 0;
  cfp_panel dut_u (
    .CORE_CLK(clk), .RST(rst),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aw), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .FREQ(freq), .MEAS(meas), .KEYS(keys), .DISP(disp), .LAMPS(lamps),
    .TIMEBASE_EXT(tbx), .IRQ(irq));
  cfp_front_model model_u (.disp(disp), .lamps(lamps), .bands_lit(bl), .units_lit(ul));
  always #5 clk = ~clk;
  // run ceiling far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  task stop_test;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task key(input logic [4:0] k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= '0;
    settle;
  endtask
  // one register access; requests held until their handshake edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ha, hw, h;
    pa = 1'b1;
    pw = w;
    h = 1'b0;
    @(posedge clk);
    awv <= w;
    wv <= w;
    brd <= w;
    arv <= ~w;
    rrd <= ~w;
    aw <= a;
    ar <= a;
    wd <= v;
    while (pa || pw) begin
      @(negedge clk);
      ha = pa & (w ? awr : arr);
      hw = pw & wrd;
      @(posedge clk);
      if (ha) begin
        awv <= 1'b0;
        arv <= 1'b0;
        pa = 1'b0;
      end
      if (hw) begin
        wv <= 1'b0;
        pw = 1'b0;
      end
    end
    while (!h) begin
      @(negedge clk);
      h = w ? bv : rv;
      d = rdat;
      r = w ? bresp : rresp;
      @(posedge clk);
    end
    brd <= 1'b0;
    rrd <= 1'b0;
    @(negedge clk);
  endtask
  task t_reset;
    settle;
    chk(lamps, 12'h004);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(d, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(r, RESP_SLVERR);
    bus(1'b1, 8'h20, 32'h1);
    chk(r, RESP_SLVERR);
  endtask
  task t_meas;
    logic [13:0] m [5] = '{14'h2000, 14'h1000, 14'h0800, 14'h0C00, 14'h0200};
    logic [11:0] e [5] = '{12'h104, 12'h404, 12'h004, 12'h204, 12'h014};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      meas <= m[i];
      settle;
      chk(lamps, e[i]);
      chk(tbx, e[i][9]);
    end
    @(posedge clk);
    meas <= '0;
  endtask
  task t_power;
    key(5'h01);
    chk(lamps, 12'h004);
    key(5'h02);
    chk(lamps, 12'h002);
    key(5'h02);
    chk(bl, 2'h1);
    @(posedge clk);
    freq <= 44'h01234567890;
    meas <= 14'h0112;
    key(5'h01);
    chk(lamps, 12'h009);
    chk(disp.digits, 44'h012345AAB12);
    chk({disp.unit, disp.dp}, 15'h2040);
    @(posedge clk);
    meas <= 14'h0012;
    settle;
    chk(disp.digits[2:0], 12'hA12);
    for (int i = 0; i < 3; i++) key(5'h02);
    chk(lamps, 12'h009);
    key(5'h01);
    key(5'h02);
    chk(lamps, 12'h004);
  endtask
  task t_freq;
    logic [43:0] f [4] = '{44'h01234567890, 44'h00001000000, 44'h00000123456, 44'h42};
    logic [14:0] e [4] = '{15'h4200, 15'h2040, 15'h1008, 15'h0800};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      freq <= f[i];
      settle;
      chk(disp.digits, f[i]);
      chk({disp.unit, disp.dp}, e[i]);
      chk(ul, 3'h1);
    end
  endtask
  task t_hold;
    logic [11:0] e [4] = '{12'h084, 12'h044, 12'h0C4, 12'h004};
    for (int i = 0; i < 4; i++) begin
      key(5'h08);
      chk(lamps, e[i]);
    end
  endtask
  task t_delta_standby;
    key(5'h04);
    chk(lamps, 12'h024);
    bus(1'b1, CTRL_OFS, 32'h10);
    settle;
    chk(lamps, 12'h004);
    bus(1'b1, CTRL_OFS, 32'h08);
    settle;
    chk(lamps, 12'h024);
    key(5'h14);
    chk(lamps, 12'h804);
    bus(1'b1, CTRL_OFS, 32'h06);
    settle;
    chk(lamps, 12'h804);
    bus(1'b1, CTRL_OFS, 32'h02);
    settle;
    chk(lamps, 12'h004);
  endtask
  task t_irq;
    bus(1'b1, IRQ_STAT_OFS, 32'h1F);
    bus(1'b1, IRQ_MASK_OFS, 32'h01);
    key(5'h08);
    chk(irq, 1'b1);
    bus(1'b1, IRQ_STAT_OFS, 32'h01);
    chk(irq, 1'b0);
    bus(1'b1, IRQ_MASK_OFS, 32'h00);
    key(5'h08);
    chk(irq, 1'b0);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(d, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_meas;
    t_power;
    t_freq;
    t_hold;
    t_delta_standby;
    t_irq;
    stop_test;
  end
endmodule // cfp_panel_tb
`default_nettype wire

// File: cfp_pkg.sv
package cfp_pkg;

  // display geometry and bus address width
  localparam int DIGITS = 11;
  localparam int AXI_AW = 8;

  // register byte offsets
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [AXI_AW-1:0] IRQ_MASK_OFS = 8'h0C;

  // control register fields
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int CTRL_BATT_BIT = 1;
  localparam int CTRL_PWRON_BIT = 2;
  localparam int CTRL_DSET_BIT = 3;
  localparam int CTRL_DCLR_BIT = 4;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // interrupt status and mask fields
  localparam int IRQ_HOLD = 0;
  localparam int IRQ_BAND = 1;
  localparam int IRQ_EXTLOST = 2;
  localparam int IRQ_OVLD = 3;
  localparam int IRQ_PWR = 4;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // status register fields
  localparam int ST_BAND_LSB = 0;
  localparam int ST_PWR = 2;
  localparam int ST_HOLD_LSB = 3;
  localparam int ST_DELTA = 5;
  localparam int ST_EXT = 6;
  localparam int ST_OVLD = 7;
  localparam int ST_GATE = 8;
  localparam int ST_STANDBY = 9;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // digit codes beyond bcd
  localparam logic [3:0] DIG_BLANK = 4'hA;
  localparam logic [3:0] DIG_MINUS = 4'hB;

  // digit positions, index 0 is the 1 Hz digit
  localparam int DP_GHZ = 9;
  localparam int DP_MHZ = 6;
  localparam int DP_KHZ = 3;
  localparam int PWR_FREQ_LSD = 5;
  localparam int PWR_SIGN_POS = 2;

  // unit annunciator one-hot positions
  localparam int UNIT_HZ = 0;
  localparam int UNIT_KHZ = 1;
  localparam int UNIT_MHZ = 2;
  localparam int UNIT_GHZ = 3;

  typedef enum logic [1:0] {
    HOLD_MIN = 2'b00,
    HOLD_SHORT = 2'b01,
    HOLD_LONG = 2'b11,
    HOLD_INF = 2'b10
  } cfp_hold_t;

  typedef enum logic [1:0] {
    BAND1_HIZ = 2'b00,
    BAND1_50 = 2'b01,
    BAND2 = 2'b11
  } cfp_band_t;

  typedef logic [DIGITS-1:0][3:0] cfp_bcd_t;

  typedef struct packed {
    logic standby;
    logic hold;
    logic delta;
    logic band;
    logic power_meter_mode;
  } cfp_keys_t;

  typedef struct packed {
    logic gate_open;
    logic remote;
    logic ext_present;
    logic ext_level_ok;
    logic overload_det;
    logic pwr_neg;
    logic [1:0][3:0] pwr_mag;
  } cfp_meas_t;

  typedef struct packed {
    cfp_bcd_t digits;
    logic [DIGITS-1:0] dp;
    logic [3:0] unit;
  } cfp_disp_t;

  typedef struct packed {
    logic standby;
    logic remote;
    logic external_timebase_lamp;
    logic gate;
    logic short_hold_lamp;
    logic long_hold_lamp;
    logic delta;
    logic overload;
    logic dbm;
    logic band1_hiz;
    logic band1_50;
    logic band2;
  } cfp_lamps_t;

endpackage
